// >>> hdl/csc_command_handler.v
// Purpose: framed ASCII command interpreter of a monochrome camera
// Assumes: byte stream in and out with valid/ready, Avalon-MM register slave
// Notes: long pulse counts are parameters so a bench can shorten them
// Behaviour
// [RL1] Temperature read answers STX ACK name data ETX, or STX NAK ETX.
// [RL2] Temperature sent as 16-bit hex, low 10 bits signed, sign-extended.
// [RL3] Trigger command makes 100 ms low pulse, only in async mode, menu hidden.
// [RL4] Host spaces trigger commands at least about 300 ms apart.
// [RL5] Command trigger sounds buzzer 50 ms unless buzzer flag is off.
// [RL6] Trigger command always gets ACK, even when no trigger is made; the code sends NAK in locked mode groups.
// [RL7] Host uses trigger command only where slow response is acceptable.
// [RL8] Full reset restores power-on state but keeps the nonvolatile ID.
// [RL9] In locked mode groups only full reset is accepted, others get NAK.
// [RL10] ID write with more than 15 characters is refused with NAK.
// [RL11] ID write with empty string deletes the ID.
// [RL12] Host keeps ID characters within letters and listed symbols.
// [RL13] Odd ID characters are stored as sent and still get ACK.
// [RL14] ID write is volatile; ID save copies it to nonvolatile store.
// [RL15] Saved ID is separate from pages and empty after manufacture.
// [RL16] ID read answers ACK, name and 0 to 15 stored characters.
// [RL17] Substrate voltage commands are unsupported and refused.
// [RL18] Gain read answers name, gain and a meaningless right field.
// [RL19] Host sends gain as two hex digits 00 to FF plus right field.
// [RL20] Host sends 00 in the right field, which is ignored.
// [RL21] Offset read answers name, offset and an unused right field.
// [RL22] Config flag write loads the 16-bit flag register from 4 hex digits.
// [RL23] Unknown, unsupported or malformed frames get NAK, no setting changes.
// [RL24] Replies use uppercase hex; commands accept either case.
`timescale 1ns/10ps
`default_nettype none
`include "csc_map.vh"

module csc_command_handler #(
	parameter TRIG_CYCLES = `CSC_TRIG_MS * `CSC_CLK_KHZ,
	parameter BUZZ_CYCLES = `CSC_BUZZ_MS * `CSC_CLK_KHZ,
	parameter CNT_W = 24
) (
	input wire clk,
	input wire rstn,
	input wire [3:0] avsAddress,
	input wire avsRead,
	input wire avsWrite,
	input wire [31:0] avsWriteData,
	output reg [31:0] avsReadData,
	output wire avsWaitRequest,
	input wire [7:0] rxData,
	input wire rxValid,
	output wire rxReady,
	output reg [7:0] txData,
	output reg txValid,
	input wire txReady,
	input wire [9:0] temperature,
	input wire [7:0] offsetLevel,
	input wire asyncShutterMode,
	input wire menuShown,
	input wire lockedModeGroup,
	output wire triggerN,
	output wire buzzerOn,
	output reg fullResetPulse,
	output reg idSavePulse,
	output wire [7:0] manualGain,
	output wire [15:0] configFlags
);

	// ****************************************
	// States and declarations
	// ****************************************
	localparam ST_IDLE = 2'b00;
	localparam ST_COPY = 2'b01;
	localparam ST_REPLY = 2'b10;

	reg [1:0] state_ff;
	reg inFrame_ff;
	reg [4:0] len_ff;
	reg ovf_ff;
	reg [55:0] head_ff;
	reg [119:0] id_ff;
	reg [3:0] idLen_ff;
	reg [119:0] nvId_ff;
	reg [3:0] nvIdLen_ff;
	reg [15:0] cfg_ff;
	reg [7:0] gain_ff;
	reg [CNT_W-1:0] trigCnt_ff;
	reg [CNT_W-1:0] buzzCnt_ff;
	reg [3:0] copyCnt_ff;
	reg [3:0] copyLen_ff;
	reg copyVld_ff;
	reg [3:0] copyIdx_ff;
	reg rpAck_ff;
	reg [2:0] rpName_ff;
	reg [3:0] rpPay_ff;
	reg rpId_ff;
	reg [15:0] rpData_ff;
	reg [4:0] txIdx_ff;
	reg lastNak_ff;
	reg avsAck_ff;
	reg [3:0] cmd;
	reg [7:0] selByte;
	wire [7:0] memRd;
	wire [7:0] b0 = head_ff[7:0];
	wire [7:0] b1 = head_ff[15:8];
	wire [7:0] b2 = head_ff[23:16];
	wire [7:0] b3 = head_ff[31:24];
	wire [7:0] b4 = head_ff[39:32];
	wire [7:0] b5 = head_ff[47:40];
	wire [7:0] b6 = head_ff[55:48];
	wire [4:0] n3 = hexNib(b3);
	wire [4:0] n4 = hexNib(b4);
	wire [4:0] n5 = hexNib(b5);
	wire [4:0] n6 = hexNib(b6);
	wire hexOk2 = n3[4] & n4[4];
	wire hexOk4 = hexOk2 & n5[4] & n6[4];
	wire [4:0] idChars = len_ff - `CSC_ID_START;
	wire rxTake = rxValid & rxReady;
	wire frameEnd = rxTake & inFrame_ff & (rxData == `CSC_ETX);
	wire dataByte = rxTake & inFrame_ff & (rxData != `CSC_ETX) & (rxData != `CSC_STX);
	wire [4:0] lastIdx = rpAck_ff ? 5'd2 + {2'b00, rpName_ff} + {1'b0, rpPay_ff} : 5'd2;
	wire avsReq = avsRead | avsWrite;
	wire trigAllowed = asyncShutterMode & ~menuShown & (trigCnt_ff == {CNT_W{1'b0}});

	// ****************************************
	// Functions
	// ****************************************
	// Hex digit in either case to {valid, nibble}
	function [4:0] hexNib;
		input [7:0] c;
		begin
			if (c >= 8'h30 && c <= 8'h39) begin
				hexNib = {1'b1, c[3:0]};
			end else if ((c >= 8'h41 && c <= 8'h46) || (c >= 8'h61 && c <= 8'h66)) begin
				hexNib = {1'b1, c[3:0] + 4'h9};
			end else begin
				hexNib = 5'h00;
			end
		end
	endfunction

	// Nibble to uppercase ASCII
	function [7:0] hexChar;
		input [3:0] v;
		begin
			if (v < 4'ha) begin
				hexChar = 8'h30 + {4'h0, v};
			end else begin
				hexChar = 8'h37 + {4'h0, v};
			end
		end
	endfunction

	// ****************************************
	// Line buffer
	// ****************************************
	csc_line_mem #(
		.W(8),
		.DEPTH(32),
		.AW(5)
	) uLineMem (
		.clk(clk),
		.rstn(rstn),
		.wrEn(dataByte & ~ovf_ff),
		.wrAddr(len_ff),
		.wrData(rxData),
		.rdAddr({1'b0, copyCnt_ff} + `CSC_ID_START),
		.rdData(memRd)
	);

	// ****************************************
	// Command decode
	// ****************************************
	// Name and length both must match, except ID write which needs at least 3 bytes; a wrong length is malformed
	always @* begin
		cmd = `CSC_CMD_BAD; // RL23
		if (ovf_ff) begin
			cmd = `CSC_CMD_BAD;
		end else if (len_ff == 5'd4 && {b0, b1, b2, b3} == 32'h52544d50) begin
			cmd = `CSC_CMD_TEMP;
		end else if (len_ff == 5'd1 && b0 == 8'h58) begin
			cmd = `CSC_CMD_TRIG;
		end else if (len_ff == 5'd6 && {b0, b1, b2, b3, b4, b5} == 48'h415245534554) begin
			cmd = `CSC_CMD_FRST;
		end else if (len_ff >= 5'd3 && {b0, b1, b2} == 24'h574944) begin
			cmd = `CSC_CMD_ID_WR;
		end else if (len_ff == 5'd3 && {b0, b1, b2} == 24'h534944) begin
			cmd = `CSC_CMD_ID_SAVE;
		end else if (len_ff == 5'd3 && {b0, b1, b2} == 24'h524944) begin
			cmd = `CSC_CMD_ID_RD;
		end else if (len_ff == 5'd3 && {b0, b1, b2} == 24'h524d47) begin
			cmd = `CSC_CMD_GAIN_RD;
		end else if (len_ff == 5'd7 && {b0, b1, b2} == 24'h574d47 && hexOk2) begin
			cmd = `CSC_CMD_GAIN_WR; // RL24
		end else if (len_ff == 5'd3 && {b0, b1, b2} == 24'h524f46) begin
			cmd = `CSC_CMD_OFS_RD;
		end else if (len_ff == 5'd7 && {b0, b1, b2} == 24'h574d43 && hexOk4) begin
			cmd = `CSC_CMD_CFG_WR;
		end
		// Substrate voltage names fall through to a refusal
	end

	// ****************************************
	// Reply byte selection
	// ****************************************
	// Byte for the index that follows the one on the line
	always @* begin : selProc
		reg [4:0] idx;
		reg [4:0] pos;
		reg [4:0] p2;
		idx = txIdx_ff + 5'd1;
		pos = idx - 5'd2;
		p2 = pos - {2'b00, rpName_ff};
		selByte = `CSC_ETX;
		if (idx == 5'd1) begin
			selByte = rpAck_ff ? `CSC_ACK : `CSC_NAK; // RL1
		end else if (!rpAck_ff || idx == lastIdx) begin
			selByte = `CSC_ETX;
		end else if (pos < {2'b00, rpName_ff}) begin
			selByte = head_ff[pos[2:0]*8 +: 8];
		end else if (rpId_ff) begin
			selByte = id_ff[p2[3:0]*8 +: 8]; // RL16
		end else begin
			selByte = hexChar(rpData_ff[(4'd3 - p2[3:0])*4 +: 4]); // RL24
		end
	end

	// ****************************************
	// Main sequencer
	// ****************************************
	// Receive, decode, act, answer; settings change only on an accepted frame or a bus write
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_ff <= ST_IDLE;
			inFrame_ff <= 1'b0;
			len_ff <= 5'h00;
			ovf_ff <= 1'b0;
			head_ff <= 56'h0;
			id_ff <= 120'h0;
			idLen_ff <= 4'h0;
			nvId_ff <= 120'h0;
			nvIdLen_ff <= 4'h0; // RL15
			cfg_ff <= `CSC_CFG_RESET;
			gain_ff <= `CSC_GAIN_RESET;
			trigCnt_ff <= {CNT_W{1'b0}};
			buzzCnt_ff <= {CNT_W{1'b0}};
			copyCnt_ff <= 4'h0;
			copyLen_ff <= 4'h0;
			copyVld_ff <= 1'b0;
			copyIdx_ff <= 4'h0;
			rpAck_ff <= 1'b0;
			rpName_ff <= 3'h0;
			rpPay_ff <= 4'h0;
			rpId_ff <= 1'b0;
			rpData_ff <= 16'h0;
			txIdx_ff <= 5'h00;
			txData <= 8'h00;
			txValid <= 1'b0;
			lastNak_ff <= 1'b0;
			fullResetPulse <= 1'b0;
			idSavePulse <= 1'b0;
		end else begin
			fullResetPulse <= 1'b0;
			idSavePulse <= 1'b0;
			// Pulse timers run down on their own
			if (trigCnt_ff != {CNT_W{1'b0}}) begin
				trigCnt_ff <= trigCnt_ff - 1'b1;
			end
			if (buzzCnt_ff != {CNT_W{1'b0}}) begin
				buzzCnt_ff <= buzzCnt_ff - 1'b1;
			end
			// Bus writes; an accepted command in the same cycle wins below
			if (avsWrite && avsAck_ff && avsAddress == `CSC_REG_CONFIG) begin
				cfg_ff <= avsWriteData[15:0];
			end
			if (avsWrite && avsAck_ff && avsAddress == `CSC_REG_GAIN) begin
				gain_ff <= avsWriteData[7:0];
			end
			// Copy lags the read address by the memory register
			copyVld_ff <= 1'b0;
			if (copyVld_ff) begin
				id_ff[copyIdx_ff*8 +: 8] <= memRd; // RL13
			end
			case (state_ff)
				ST_IDLE: begin
					if (rxTake && rxData == `CSC_STX) begin
						inFrame_ff <= 1'b1;
						len_ff <= 5'h00;
						ovf_ff <= 1'b0;
					end else if (dataByte) begin
						if (len_ff < `CSC_HEAD_LEN) begin
							head_ff[len_ff[2:0]*8 +: 8] <= rxData;
						end
						if (len_ff == `CSC_LEN_MAX) begin
							ovf_ff <= 1'b1; // RL10
						end else begin
							len_ff <= len_ff + 5'd1;
						end
					end else if (frameEnd) begin
						inFrame_ff <= 1'b0;
						state_ff <= ST_REPLY;
						txIdx_ff <= 5'h00;
						txData <= `CSC_STX;
						txValid <= 1'b1;
						rpAck_ff <= 1'b1;
						rpName_ff <= 3'h0;
						rpPay_ff <= 4'h0;
						rpId_ff <= 1'b0;
						lastNak_ff <= 1'b0;
						if (lockedModeGroup && cmd != `CSC_CMD_FRST) begin
							rpAck_ff <= 1'b0; // RL9
							lastNak_ff <= 1'b1;
						end else begin
							case (cmd)
								`CSC_CMD_TEMP: begin
									rpName_ff <= 3'd4;
									rpPay_ff <= `CSC_HEX_DIGITS;
									rpData_ff <= {{6{temperature[9]}}, temperature}; // RL2
								end
								`CSC_CMD_TRIG: begin
									// Acknowledged whether or not a pulse is made
									if (trigAllowed) begin // RL6
										trigCnt_ff <= TRIG_CYCLES[CNT_W-1:0]; // RL3
										if (cfg_ff[`CSC_CFG_BUZZ_BIT]) begin
											buzzCnt_ff <= BUZZ_CYCLES[CNT_W-1:0]; // RL5
										end
									end
								end
								`CSC_CMD_FRST: begin
									// Power-on state again; nonvolatile copy survives
									fullResetPulse <= 1'b1; // RL8
									id_ff <= nvId_ff;
									idLen_ff <= nvIdLen_ff;
									cfg_ff <= `CSC_CFG_RESET;
									gain_ff <= `CSC_GAIN_RESET;
									trigCnt_ff <= {CNT_W{1'b0}};
									buzzCnt_ff <= {CNT_W{1'b0}};
								end
								`CSC_CMD_ID_WR: begin
									if (idChars > `CSC_ID_MAX) begin
										rpAck_ff <= 1'b0; // RL10
										lastNak_ff <= 1'b1;
									end else if (idChars == 5'h00) begin
										idLen_ff <= 4'h0; // RL11
									end else begin
										state_ff <= ST_COPY;
										txValid <= 1'b0;
										copyCnt_ff <= 4'h0;
										copyLen_ff <= idChars[3:0];
									end
								end
								`CSC_CMD_ID_SAVE: begin
									nvId_ff <= id_ff; // RL14
									nvIdLen_ff <= idLen_ff;
									idSavePulse <= 1'b1;
								end
								`CSC_CMD_ID_RD: begin
									rpName_ff <= 3'd3;
									rpPay_ff <= idLen_ff; // RL16
									rpId_ff <= 1'b1;
								end
								`CSC_CMD_GAIN_RD: begin
									rpName_ff <= 3'd3;
									rpPay_ff <= `CSC_HEX_DIGITS;
									rpData_ff <= {gain_ff, `CSC_RIGHT_FIELD}; // RL18
								end
								`CSC_CMD_GAIN_WR: begin
									gain_ff <= {n3[3:0], n4[3:0]}; // RL20
								end
								`CSC_CMD_OFS_RD: begin
									rpName_ff <= 3'd3;
									rpPay_ff <= `CSC_HEX_DIGITS;
									rpData_ff <= {offsetLevel, `CSC_RIGHT_FIELD}; // RL21
								end
								`CSC_CMD_CFG_WR: begin
									cfg_ff <= {n3[3:0], n4[3:0], n5[3:0], n6[3:0]}; // RL22
								end
								default: begin
									rpAck_ff <= 1'b0; // RL17
									lastNak_ff <= 1'b1;
								end
							endcase
						end
					end
				end
				ST_COPY: begin
					// Volatile copy only; saving is a separate command
					if (copyCnt_ff < copyLen_ff) begin
						copyCnt_ff <= copyCnt_ff + 4'd1;
						copyVld_ff <= 1'b1;
						copyIdx_ff <= copyCnt_ff;
					end else if (!copyVld_ff) begin
						idLen_ff <= copyLen_ff; // RL14
						state_ff <= ST_REPLY;
						txIdx_ff <= 5'h00;
						txData <= `CSC_STX;
						txValid <= 1'b1;
					end
				end
				ST_REPLY: begin
					if (txReady) begin
						if (txIdx_ff == lastIdx) begin
							txValid <= 1'b0;
							state_ff <= ST_IDLE;
						end else begin
							txIdx_ff <= txIdx_ff + 5'd1;
							txData <= selByte; // RL1
						end
					end
				end
				default: begin
					state_ff <= ST_IDLE;
					txValid <= 1'b0;
				end
			endcase
		end
	end

	// ****************************************
	// Avalon-MM slave
	// ****************************************
	// One wait cycle per access; read data captured while waiting
	assign avsWaitRequest = avsReq & ~avsAck_ff;

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			avsAck_ff <= 1'b0;
			avsReadData <= 32'h0;
		end else begin
			avsAck_ff <= avsReq & ~avsAck_ff;
			if (avsRead && !avsAck_ff) begin
				case (avsAddress)
					`CSC_REG_CONFIG: avsReadData <= {16'h0, cfg_ff};
					`CSC_REG_GAIN: avsReadData <= {24'h0, gain_ff};
					`CSC_REG_STATUS: avsReadData <= {24'h0, state_ff != ST_IDLE,
						trigCnt_ff != {CNT_W{1'b0}}, buzzCnt_ff != {CNT_W{1'b0}},
						lastNak_ff, idLen_ff};
					default: avsReadData <= 32'h0;
				endcase
			end
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	// Frame reception stalls while a reply or copy is pending
	assign rxReady = (state_ff == ST_IDLE);
	assign triggerN = (trigCnt_ff == {CNT_W{1'b0}}); // RL3
	assign buzzerOn = (buzzCnt_ff != {CNT_W{1'b0}}); // RL5
	assign manualGain = gain_ff;
	assign configFlags = cfg_ff;

endmodule
`default_nettype wire

// >>> hdl/csc_line_mem.v
// Purpose: line buffer holding the body of one received command frame
// Assumes: one write and one read port on the same clock
// Notes: read data come out of a register one cycle after the address
`timescale 1ns/10ps
`default_nettype none

module csc_line_mem #(
	parameter W = 8,
	parameter DEPTH = 32,
	parameter AW = 5
) (
	input wire clk,
	input wire rstn,
	input wire wrEn,
	input wire [AW-1:0] wrAddr,
	input wire [W-1:0] wrData,
	input wire [AW-1:0] rdAddr,
	output reg [W-1:0] rdData
);

	reg [W-1:0] mem [0:DEPTH-1];

	// Storage array, no reset needed
	always @(posedge clk) begin
		if (wrEn) begin
			mem[wrAddr] <= wrData;
		end
	end

	// Registered read port
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rdData <= {W{1'b0}};
		end else begin
			rdData <= mem[rdAddr];
		end
	end

endmodule
`default_nettype wire

// >>> hdl/csc_map.vh
// Purpose: constants of the camera serial command handler
// Assumes: included by the handler, its checker, the host model and the bench
// Notes: definitions only
`ifndef CSC_MAP_VH
`define CSC_MAP_VH

// ****************************************
// Frame control characters
// ****************************************
`define CSC_STX 8'h02
`define CSC_ETX 8'h03
`define CSC_ACK 8'h06
`define CSC_NAK 8'h15

// ****************************************
// Avalon register byte offsets
// ****************************************
`define CSC_REG_CONFIG 4'h0
`define CSC_REG_GAIN 4'h4
`define CSC_REG_STATUS 4'h8

// ****************************************
// Fields and reset values
// ****************************************
`define CSC_CFG_BUZZ_BIT 0
`define CSC_CFG_RESET 16'h0001
`define CSC_GAIN_RESET 8'h00
`define CSC_RIGHT_FIELD 8'h00
`define CSC_ID_MAX 5'h0f
`define CSC_HEAD_LEN 5'h07
`define CSC_LEN_MAX 5'h1f
`define CSC_ID_START 5'h03
`define CSC_HEX_DIGITS 4'h4

// ****************************************
// Timing (ms at a clock given in kHz)
// ****************************************
`define CSC_CLK_KHZ 125000
`define CSC_TRIG_MS 100
`define CSC_BUZZ_MS 50

// ****************************************
// Decoded commands
// ****************************************
`define CSC_CMD_BAD 4'h0
`define CSC_CMD_TEMP 4'h1
`define CSC_CMD_TRIG 4'h2
`define CSC_CMD_FRST 4'h3
`define CSC_CMD_ID_WR 4'h4
`define CSC_CMD_ID_SAVE 4'h5
`define CSC_CMD_ID_RD 4'h6
`define CSC_CMD_GAIN_RD 4'h7
`define CSC_CMD_GAIN_WR 4'h8
`define CSC_CMD_OFS_RD 4'h9
`define CSC_CMD_CFG_WR 4'ha

`endif

// >>> verif/csc_command_handler_asserts.sv
// Purpose: port checks of the camera serial command handler
// Assumes: one clock, rstn asynchronous and active low
// Notes: pulse widths are checked against the shortened counts
`timescale 1ns/10ps
`default_nettype none
`include "csc_map.vh"
// ****************************************
// Checker
// ****************************************
module csc_command_handler_asserts #(
	parameter TRIG_CYCLES = 40,
	parameter BUZZ_CYCLES = 20,
	parameter CNT_W = 24
) (
	input wire clk,
	input wire rstn,
	input wire avsRead,
	input wire avsWrite,
	input wire avsWaitRequest,
	input wire rxReady,
	input wire [7:0] txData,
	input wire txValid,
	input wire txReady,
	input wire asyncShutterMode,
	input wire menuShown,
	input wire lockedModeGroup,
	input wire triggerN,
	input wire buzzerOn,
	input wire fullResetPulse,
	input wire idSavePulse,
	input wire [15:0] configFlags
);
	reg [31:0] lowCnt_ff;
	reg [31:0] buzCnt_ff;
	// Run lengths of both pulses, too long for a repetition
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			lowCnt_ff <= 32'h0;
			buzCnt_ff <= 32'h0;
		end else begin
			lowCnt_ff <= triggerN ? 32'h0 : lowCnt_ff + 32'h1;
			buzCnt_ff <= buzzerOn ? buzCnt_ff + 32'h1 : 32'h0;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	sequence sOneWait;
		avsWaitRequest ##1 !avsWaitRequest;
	endsequence
	sequence sTrigStart;
		$fell(triggerN);
	endsequence
	a_bus_one_wait: assert property ($rose(avsRead | avsWrite) |-> sOneWait)
		else $error("bus wait not one cycle");
	a_trig_width: assert property ($rose(triggerN) |-> lowCnt_ff == TRIG_CYCLES)
		else $error("trigger pulse width wrong");
	a_trig_gated: assert property (sTrigStart |-> asyncShutterMode && !menuShown && !lockedModeGroup)
		else $error("trigger in wrong mode");
	a_buzz_cause: assert property ($rose(buzzerOn) |-> !triggerN && configFlags[0])
		else $error("buzzer without trigger or enable");
	a_buzz_width: assert property ($fell(buzzerOn) |-> buzCnt_ff == BUZZ_CYCLES)
		else $error("buzzer width wrong");
	a_reply_start: assert property ($rose(txValid) |-> txData == `CSC_STX)
		else $error("reply not opened by start byte");
	a_tx_hold: assert property (txValid && !txReady |=> txValid && $stable(txData))
		else $error("reply byte dropped while stalled");
	a_rx_closed: assert property (txValid |-> !rxReady)
		else $error("command taken during reply");
	a_pulse_single: assert property (fullResetPulse || idSavePulse |=> !fullResetPulse && !idSavePulse)
		else $error("pulse longer than one cycle");
endmodule

bind csc_command_handler csc_command_handler_asserts #(.TRIG_CYCLES(TRIG_CYCLES),
	.BUZZ_CYCLES(BUZZ_CYCLES), .CNT_W(CNT_W)) chk_u (.clk, .rstn, .avsRead, .avsWrite,
	.avsWaitRequest, .rxReady, .txData, .txValid, .txReady, .asyncShutterMode, .menuShown,
	.lockedModeGroup, .triggerN, .buzzerOn, .fullResetPulse, .idSavePulse, .configFlags);
`default_nettype wire

// >>> verif/csc_host_model.sv
// Purpose: host computer sending framed commands and taking replies
// Assumes: valid/ready byte handshake in both directions
// Notes: stall makes the reply sink slow
`timescale 1ns/10ps
`default_nettype none
`include "csc_map.vh"
// ****************************************
// Host model
// ****************************************
module csc_host_model (
	input wire logic clk,
	input wire logic rstn,
	output logic [7:0] rxData,
	output logic rxValid,
	input wire logic rxReady,
	input wire logic [7:0] txData,
	input wire logic txValid,
	output logic txReady,
	input wire logic stall
);
	logic [7:0] got[$];
	initial begin
		rxData = 8'h5a;
		rxValid = 1'b0;
	end
	// Collect reply bytes at each accepted handshake
	always @(posedge clk) begin
		txReady <= !stall;
		if (txValid && txReady)
			got.push_back(txData);
	end
	// Each byte held until taken; idle line shows no stale byte
	task automatic sendFrame(input logic [7:0] body[$]);
		logic [7:0] f[$];
		f = {`CSC_STX, body, `CSC_ETX};
		foreach (f[i]) begin
			rxData <= f[i];
			rxValid <= 1'b1;
			@(posedge clk);
			while (rxReady !== 1'b1)
				@(posedge clk);
		end
		rxValid <= 1'b0;
		rxData <= ~f[f.size() - 1];
	endtask
endmodule
`default_nettype wire

// >>> verif/tb_top.sv
// Purpose: self-checking bench of the camera serial command handler
// Assumes: pulse counts shortened to TRIG and BUZZ
// Notes: replies are compared with a queue model kept here
`timescale 1ns/10ps
`default_nettype none
`include "csc_map.vh"
// ****************************************
// Bench
// ****************************************
module tb_top;
	localparam int TRIG = 40;
	localparam int BUZZ = 20;
	logic clk, rstn, avsRead, avsWrite, avsWaitRequest, rxValid, rxReady, txValid, txReady;
	logic asyncShutterMode, menuShown, lockedModeGroup, triggerN, buzzerOn;
	logic fullResetPulse, idSavePulse, slow;
	logic stall = 1'b0;
	logic [7:0] rnd = 8'h61;
	logic [3:0] avsAddress;
	logic [31:0] avsWriteData, avsReadData, r;
	logic [7:0] rxData, txData, offsetLevel, manualGain, g;
	logic [9:0] temperature;
	logic [15:0] configFlags, t;
	logic [7:0] tx[$], ex[$], idQ[$], savedQ[$];
	logic [63:0] bad[4] = '{64'h5756535542, 64'h5356535542, 64'h5256535542, 64'h5a5a};
	int errors = 0, comparisons = 0, trigFalls = 0, buzzRises = 0, resets = 0, saves = 0;

	csc_command_handler #(.TRIG_CYCLES(TRIG), .BUZZ_CYCLES(BUZZ)) dut_u (.clk, .rstn, .avsAddress,
		.avsRead, .avsWrite, .avsWriteData, .avsReadData, .avsWaitRequest, .rxData, .rxValid,
		.rxReady, .txData, .txValid, .txReady, .temperature, .offsetLevel, .asyncShutterMode,
		.menuShown, .lockedModeGroup, .triggerN, .buzzerOn, .fullResetPulse, .idSavePulse,
		.manualGain, .configFlags);
	csc_host_model host_u (.clk, .rstn, .rxData, .rxValid, .rxReady, .txData, .txValid,
		.txReady, .stall);

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// Free-running lfsr also paces the slow reply sink
	always @(posedge clk) begin
		rnd <= lfsr(rnd);
		stall <= slow & rnd[0];
	end
	always @(negedge triggerN) trigFalls++;
	always @(posedge buzzerOn) buzzRises++;
	always @(posedge fullResetPulse) resets++;
	always @(posedge idSavePulse) saves++;

	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	function automatic logic [7:0] hx(input logic [3:0] v, input logic lo);
		return v < 4'ha ? 8'h30 + v : (lo ? 8'h57 : 8'h37) + v;
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic put(inout logic [7:0] q[$], input logic [63:0] s, input int n);
		for (int i = n - 1; i >= 0; i--)
			q.push_back(s[8 * i +: 8]);
	endtask
	task automatic hex2(inout logic [7:0] q[$], input logic [7:0] v, input logic lo);
		q.push_back(hx(v[7:4], lo));
		q.push_back(hx(v[3:0], lo));
	endtask
	// Request held until waitrequest is seen low
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
		output logic [31:0] rd);
		avsAddress <= a;
		avsWriteData <= d;
		avsWrite <= wr;
		avsRead <= !wr;
		@(posedge clk);
		while (avsWaitRequest !== 1'b0)
			@(posedge clk);
		rd = avsReadData;
		avsRead <= 1'b0;
		avsWrite <= 1'b0;
		@(posedge clk);
	endtask
	// Send the frame in tx, compare the whole reply with the model
	task automatic run(input logic ack);
		int n;
		logic [7:0] e[$];
		n = 0;
		e = {`CSC_STX, ack ? `CSC_ACK : `CSC_NAK};
		if (ack)
			e = {e, ex};
		e.push_back(`CSC_ETX);
		host_u.got.delete();
		host_u.sendFrame(tx);
		while ((host_u.got.size() == 0 || host_u.got[$] !== `CSC_ETX) && n < 400) begin
			n++;
			@(posedge clk);
		end
		check(host_u.got.size(), e.size());
		foreach (e[i])
			check(host_u.got[i], e[i]);
		tx.delete();
		ex.delete();
	endtask
	task automatic askGain();
		put(tx, 24'h524d47, 3);
		put(ex, 24'h524d47, 3);
		hex2(ex, g, 1'b0);
		put(ex, 16'h3030, 2);
		run(1'b1);
	endtask
	task automatic askId();
		put(tx, 24'h524944, 3);
		put(ex, 24'h524944, 3);
		ex = {ex, idQ};
		run(1'b1);
	endtask
	// Trigger command under one mode; wait spans the scaled 300 ms pitch
	task automatic trig(input logic a, input logic m, input int tf, input int br);
		asyncShutterMode <= a;
		menuShown <= m;
		put(tx, 8'h58, 1);
		run(1'b1);
		repeat (3 * TRIG) @(posedge clk);
		check(trigFalls, tf);
		check(buzzRises, br);
	endtask
	task automatic wrap_up();
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	initial begin
		#200000;
		errors++;
		wrap_up();
	end
	initial begin
		{avsRead, avsWrite, asyncShutterMode, menuShown, lockedModeGroup, slow} = 6'h0;
		avsAddress = 4'h0;
		avsWriteData = 32'h0;
		temperature = 10'h0;
		offsetLevel = 8'h0;
		rstn = 1'b0;
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		check(manualGain, 8'h00);
		check(configFlags, 16'h0001);
		bus(1'b0, 4'h0, 32'h0, r);
		check(r, 32'h1);
		bus(1'b0, 4'hc, 32'h0, r);
		check(r, 32'h0);
		g = rnd;
		bus(1'b1, 4'h4, {24'h0, g}, r);
		bus(1'b0, 4'h4, 32'h0, r);
		check(r, {24'h0, g});
		askGain();
		g = rnd;
		put(tx, 24'h574d47, 3);
		hex2(tx, g, 1'b1);
		put(tx, 16'h3030, 2);
		run(1'b1);
		check(manualGain, g);
		askGain();
		put(tx, 56'h574d4747303030, 7);
		run(1'b0);
		check(manualGain, g);
		t = {6'h3f, 2'b10, rnd};
		temperature <= t[9:0];
		put(tx, 32'h52544d50, 4);
		put(ex, 32'h52544d50, 4);
		hex2(ex, t[15:8], 1'b0);
		hex2(ex, t[7:0], 1'b0);
		run(1'b1);
		g = rnd;
		offsetLevel <= g;
		put(tx, 24'h524f46, 3);
		put(ex, 24'h524f46, 3);
		hex2(ex, g, 1'b0);
		put(ex, 16'h3030, 2);
		run(1'b1);
		askId();
		for (int i = 0; i < 15; i++)
			idQ.push_back(8'h41 + i);
		put(tx, 24'h574944, 3);
		tx = {tx, idQ};
		run(1'b1);
		askId();
		put(tx, 24'h574944, 3);
		tx = {tx, idQ, 8'h5f};
		run(1'b0);
		askId();
		put(tx, 24'h534944, 3);
		run(1'b1);
		savedQ = idQ;
		check(saves, 1);
		slow <= 1'b1;
		put(tx, 40'h5749447e20, 5);
		run(1'b1);
		put(tx, 24'h574944, 3);
		run(1'b1);
		idQ.delete();
		askId();
		put(tx, 48'h415245534554, 6);
		run(1'b1);
		check(resets, 1);
		check(manualGain, 8'h00);
		idQ = savedQ;
		askId();
		foreach (bad[i]) begin
			put(tx, bad[i], i < 3 ? 5 : 2);
			run(1'b0);
		end
		trig(1'b1, 1'b0, 1, 1);
		trig(1'b1, 1'b1, 1, 1);
		trig(1'b0, 1'b0, 1, 1);
		put(tx, 56'h574d4330303030, 7);
		run(1'b1);
		check(configFlags, 16'h0000);
		trig(1'b1, 1'b0, 2, 1);
		lockedModeGroup <= 1'b1;
		put(tx, 24'h524d47, 3);
		run(1'b0);
		put(tx, 24'h534944, 3);
		run(1'b0);
		check(saves, 1);
		// Status: idle, no pulses, last reply refused, 15 ID characters
		bus(1'b0, 4'h8, 32'h0, r);
		check(r, 32'h1f);
		put(tx, 48'h415245534554, 6);
		run(1'b1);
		check(resets, 2);
		wrap_up();
	end
endmodule
`default_nettype wire
